// ==== sfc_pkg.sv ====
// Contract
// - opcode 35h switches commands to four lines
// - opcode F5h returns commands to one line
// - dummy count from configuration bits 6 and 7
// - three address bytes, four in wide mode
// - EBh quad read, both modes, 6 dummies
// - 38h single-line only, 1-256 quad data bytes (code sends the length register count, 0 to 511, unchecked)
// - EDh four-line double-rate read until deselect
// - BDh single-line only, two-line double-rate read
// - 3Bh one-line address, two-line data out
// - 6Bh one-line address, four-line data out
// - BBh two-line address, dummies and data
// - non-data commands end on byte boundary
`default_nettype none
package sfc_pkg;
    // ==========================================
    // software register map (byte addresses)
    localparam logic [7:0] SFC_REG_CTRL = 8'h00;
    localparam logic [7:0] SFC_REG_ADDR = 8'h04;
    localparam logic [7:0] SFC_REG_LEN = 8'h08;
    localparam logic [7:0] SFC_REG_CFG = 8'h0C;
    localparam logic [7:0] SFC_REG_STAT = 8'h10;
    localparam logic [7:0] SFC_REG_TXD = 8'h14;
    localparam logic [7:0] SFC_REG_RXD = 8'h18;
    // field positions
    localparam int SFC_CFG_WIDE_BIT = 0;
    localparam int SFC_CFG_DC_LO_BIT = 6;
    localparam int SFC_CFG_DC_HI_BIT = 7;
    localparam logic [31:0] SFC_CFG_RST = 32'h0000_0000;
    localparam logic [8:0] SFC_LEN_RST = 9'h001;
    // ==========================================
    // opcodes
    localparam logic [7:0] SFC_OP_QUAD_CMD_ENABLE = 8'h35;
    localparam logic [7:0] SFC_OP_QUAD_CMD_RESET = 8'hF5;
    localparam logic [7:0] SFC_OP_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] SFC_OP_QUAD_PAGE_PROGRAM = 8'h38;
    localparam logic [7:0] SFC_OP_QUAD_IO_DOUBLE_RATE_READ = 8'hED;
    localparam logic [7:0] SFC_OP_DUAL_IO_DOUBLE_RATE_READ = 8'hBD;
    localparam logic [7:0] SFC_OP_DUAL_OUTPUT_READ = 8'h3B;
    localparam logic [7:0] SFC_OP_QUAD_OUTPUT_READ = 8'h6B;
    localparam logic [7:0] SFC_OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] SFC_OP_HALF_BLOCK_ERASE = 8'h52;
    // ==========================================
    // timing
    localparam int SFC_CLK_NS = 25;
    localparam logic [2:0] SFC_SCK_HALF_CYC = 3'h4;
    localparam int SFC_TSHSL_NS = 50;
    localparam logic [5:0] SFC_TSHSL_CYC = 6'((SFC_TSHSL_NS + SFC_CLK_NS - 1) / SFC_CLK_NS);
    localparam logic [5:0] SFC_QIO_READ_DUMMY = 6'h06;
    // dummy cycles per dummy_cfg_high:dummy_cfg_low setting
    localparam logic [23:0] SFC_DUMMY_TAB = {6'h0A, 6'h08, 6'h06, 6'h08};
    localparam logic [5:0] SFC_PAGE_BYTES = 6'h20;
    // ==========================================
    typedef enum logic [1:0] {SFC_DIR_NONE, SFC_DIR_RD, SFC_DIR_WR} sfc_dir_t;
    typedef struct packed {
        logic ok;
        logic has_addr;
        logic [1:0] alg;
        logic [1:0] dlg;
        logic dtr;
        sfc_dir_t dir;
        logic [5:0] dum;
    } sfc_dec_t;
endpackage
`default_nettype wire

// ==== sfc_host.sv ====
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// read-data fifo
module sfc_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW:0] wp_q, wp_d, rp_q, rp_d;

    assign in_ready = (wp_q - rp_q) != (AW + 1)'(D);
    assign out_valid = wp_q != rp_q;
    assign out_data = mem_q[rp_q[AW-1:0]];

    always_comb begin
        wp_d = wp_q + (AW + 1)'(in_valid && in_ready);
        rp_d = rp_q + (AW + 1)'(out_valid && out_ready);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (in_valid && in_ready) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end
endmodule

// ==========================================
// serial flash host controller
module sfc_host (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // software register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // flash pins
    output logic flash_cs_b,
    output logic flash_sclk,
    input wire logic [3:0] flash_io_in,
    output logic [3:0] flash_io_out,
    output logic [3:0] flash_io_oe
);
    import sfc_pkg::*;

    typedef enum {S_IDLE, S_RUN, S_END} sfc_st_t;
    typedef enum {P_CMD, P_ADDR, P_DUM, P_WR, P_RD} sfc_ph_t;

    sfc_st_t st_q, st_d;
    sfc_ph_t ph_q, ph_d;
    sfc_dec_t dec_q, dec_d, dec_c;
    logic [7:0] op_q, op_d, tx_q, tx_d, rx_q, rx_d, rxb_q, rxb_d;
    logic [31:0] addr_q, addr_d, cfg_q, cfg_d, sh_q, sh_d, rdata_q, rdata_d;
    logic [8:0] len_q, len_d, cnt_q, cnt_d;
    logic [2:0] div_q, div_d;
    logic [3:0] nb_q, nb_d, io_m_q, io_s_q, bits;
    logic [1:0] lg_q, lg_d;
    logic quad_q, quad_d, txv_q, txv_d, rej_q, rej_d, ld_q, ld_d;
    logic push_q, push_d, sclk_q, sclk_d, cs_b_q, cs_b_d;
    logic rx_ready, rx_valid, rx_pop, stall, edge_now;
    logic [7:0] rx_out;
    logic [5:0] dc_dum;

    // ==========================================
    // pin input synchroniser
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            io_m_q <= 4'h0;
            io_s_q <= 4'h0;
        end else begin
            io_m_q <= flash_io_in;
            io_s_q <= io_m_q;
        end
    end

    sfc_fifo #(.W(8), .D(4)) u_rx_fifo (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .in_valid(push_q),
        .in_ready(rx_ready),
        .in_data(rxb_q),
        .out_valid(rx_valid),
        .out_ready(rx_pop),
        .out_data(rx_out)
    );

    assign rx_pop = reg_rd && reg_addr == SFC_REG_RXD && rx_valid;
    // dummy count follows configuration bits 6..7
    assign dc_dum = SFC_DUMMY_TAB[6 * {cfg_q[SFC_CFG_DC_HI_BIT], cfg_q[SFC_CFG_DC_LO_BIT]} +: 6];

    // ==========================================
    // opcode decode against the current command mode
    always_comb begin
        dec_c = '0;
        dec_c.ok = 1'b1;
        dec_c.has_addr = 1'b1;
        dec_c.dum = dc_dum;
        case (op_q)
            SFC_OP_QUAD_CMD_ENABLE, SFC_OP_QUAD_CMD_RESET: begin
                // no address and no dummies, so deselect follows the opcode byte
                dec_c.has_addr = 1'b0;
                dec_c.dum = 6'h00;
            end
            SFC_OP_QUAD_IO_READ: begin
                dec_c = '{1'b1, 1'b1, 2'd2, 2'd2, 1'b0, SFC_DIR_RD, SFC_QIO_READ_DUMMY};
            end
            SFC_OP_QUAD_PAGE_PROGRAM: begin
                dec_c = '{!quad_q, 1'b1, 2'd2, 2'd2, 1'b0, SFC_DIR_WR, 6'h00};
            end
            SFC_OP_QUAD_IO_DOUBLE_RATE_READ: begin
                dec_c = '{1'b1, 1'b1, 2'd2, 2'd2, 1'b1, SFC_DIR_RD, dc_dum};
            end
            SFC_OP_DUAL_IO_DOUBLE_RATE_READ: begin
                dec_c = '{!quad_q, 1'b1, 2'd1, 2'd1, 1'b1, SFC_DIR_RD, dc_dum};
            end
            SFC_OP_DUAL_OUTPUT_READ: begin
                dec_c = '{!quad_q, 1'b1, 2'd0, 2'd1, 1'b0, SFC_DIR_RD, dc_dum};
            end
            SFC_OP_QUAD_OUTPUT_READ: begin
                dec_c = '{!quad_q, 1'b1, 2'd0, 2'd2, 1'b0, SFC_DIR_RD, dc_dum};
            end
            SFC_OP_DUAL_IO_READ: begin
                dec_c = '{!quad_q, 1'b1, 2'd1, 2'd1, 1'b0, SFC_DIR_RD, dc_dum};
            end
            SFC_OP_HALF_BLOCK_ERASE: begin
                dec_c.dum = 6'h00;
            end
            default: begin
                dec_c.ok = 1'b0;
            end
        endcase
        // four-line command mode carries every phase on four lines
        if (quad_q) begin
            dec_c.alg = 2'd2;
        end
    end

    // ==========================================
    // registers and transfer engine
    always_comb begin
        st_d = st_q;
        ph_d = ph_q;
        dec_d = dec_q;
        op_d = op_q;
        addr_d = addr_q;
        len_d = len_q;
        cfg_d = cfg_q;
        tx_d = tx_q;
        txv_d = txv_q;
        rej_d = rej_q;
        quad_d = quad_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        div_d = div_q;
        lg_d = lg_q;
        ld_d = ld_q;
        nb_d = nb_q;
        rx_d = rx_q;
        rxb_d = rxb_q;
        push_d = 1'b0;
        sclk_d = sclk_q;
        cs_b_d = cs_b_q;
        rdata_d = 32'h0000_0000;
        bits = (lg_q == 2'd0) ? {3'h0, io_s_q[1]} :
               (lg_q == 2'd1) ? {2'h0, io_s_q[1:0]} : io_s_q;
        stall = (ph_q == P_WR && ld_q) ||
                (ph_q == P_RD && nb_q == 4'h0 && !sclk_q && !rx_ready);
        edge_now = st_q == S_RUN && !stall && div_q == SFC_SCK_HALF_CYC - 3'h1;
        if (reg_rd) begin
            case (reg_addr)
                SFC_REG_CTRL: rdata_d = {24'h0, op_q};
                SFC_REG_ADDR: rdata_d = addr_q;
                SFC_REG_LEN: rdata_d = {23'h0, len_q};
                SFC_REG_CFG: rdata_d = cfg_q;
                SFC_REG_STAT: rdata_d = {27'h0, rx_valid, !txv_q, rej_q, quad_q, st_q != S_IDLE};
                SFC_REG_RXD: rdata_d = {24'h0, rx_out};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        if (reg_wr && st_q == S_IDLE) begin
            case (reg_addr)
                SFC_REG_CTRL: op_d = reg_wdata[7:0];
                SFC_REG_ADDR: addr_d = reg_wdata;
                SFC_REG_LEN: len_d = reg_wdata[8:0];
                SFC_REG_CFG: cfg_d = reg_wdata;
                default: ;
            endcase
        end
        case (st_q)
            S_IDLE: begin
                sclk_d = 1'b0;
                cs_b_d = 1'b1;
                if (reg_wr && reg_addr == SFC_REG_CTRL) begin
                    st_d = S_RUN;
                    rej_d = 1'b0;
                end
            end
            S_RUN: begin
                // first run cycle: decode and load the opcode
                if (cs_b_q) begin
                    dec_d = dec_c;
                    if (!dec_c.ok) begin
                        rej_d = 1'b1;
                        st_d = S_IDLE;
                    end else begin
                        cs_b_d = 1'b0;
                        ph_d = P_CMD;
                        sh_d = {op_q, 24'h0};
                        lg_d = quad_q ? 2'd2 : 2'd0;
                        cnt_d = 9'd8 >> (quad_q ? 2'd2 : 2'd0);
                        div_d = 3'h0;
                    end
                end else if (ph_q == P_WR && ld_q) begin
                    if (txv_q) begin
                        sh_d = {tx_q, 24'h0};
                        cnt_d = 9'd8 >> lg_q;
                        txv_d = 1'b0;
                        ld_d = 1'b0;
                        len_d = len_q - 9'h001;
                    end
                end else if (!stall) begin
                    div_d = edge_now ? 3'h0 : div_q + 3'h1;
                end
                if (edge_now && !cs_b_q) begin
                    sclk_d = !sclk_q;
                    if (ph_q == P_RD && (!sclk_q || dec_q.dtr)) begin
                        rx_d = 8'((rx_q << (1 << lg_q)) | {4'h0, bits});
                        nb_d = nb_q + 4'(1 << lg_q);
                        if (nb_d == 4'h8) begin
                            nb_d = 4'h0;
                            push_d = 1'b1;
                            rxb_d = rx_d;
                            len_d = len_q - 9'h001;
                            if (len_q == 9'h001) begin
                                st_d = S_END;
                                sclk_d = 1'b0;
                                cnt_d = {3'h0, SFC_TSHSL_CYC};
                            end
                        end
                    end else if (sclk_q && ph_q != P_RD) begin
                        sh_d = sh_q << (1 << lg_q);
                        cnt_d = cnt_q - 9'h001;
                        if (cnt_q == 9'h001) begin
                            if (ph_q == P_CMD && dec_q.has_addr) begin
                                ph_d = P_ADDR;
                                lg_d = dec_q.alg;
                                // three address bytes unless wide mode is on
                                sh_d = cfg_q[SFC_CFG_WIDE_BIT] ? addr_q : {addr_q[23:0], 8'h0};
                                cnt_d = (cfg_q[SFC_CFG_WIDE_BIT] ? 9'd32 : 9'd24) >> dec_q.alg;
                            end else if (ph_q != P_DUM && ph_q != P_WR && dec_q.dum != 6'h00) begin
                                ph_d = P_DUM;
                                cnt_d = {3'h0, dec_q.dum};
                            end else if (dec_q.dir == SFC_DIR_RD && len_q != 9'h000) begin
                                ph_d = P_RD;
                                lg_d = dec_q.dlg;
                                nb_d = 4'h0;
                            end else if (dec_q.dir == SFC_DIR_WR && len_q != 9'h000) begin
                                ph_d = P_WR;
                                lg_d = dec_q.dlg;
                                ld_d = 1'b1;
                            end else begin
                                // deselect lands on a byte boundary
                                st_d = S_END;
                                cnt_d = {3'h0, SFC_TSHSL_CYC};
                            end
                        end
                    end
                end
            end
            S_END: begin
                cs_b_d = 1'b1;
                sclk_d = 1'b0;
                cnt_d = cnt_q - 9'h001;
                if (cnt_q == 9'h001) begin
                    st_d = S_IDLE;
                    if (op_q == SFC_OP_QUAD_CMD_ENABLE) begin
                        quad_d = 1'b1;
                    end else if (op_q == SFC_OP_QUAD_CMD_RESET) begin
                        quad_d = 1'b0;
                    end
                end
            end
            default: st_d = S_IDLE;
        endcase
        // a new byte written in the cycle it is taken still counts
        if (reg_wr && reg_addr == SFC_REG_TXD) begin
            tx_d = reg_wdata[7:0];
            txv_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= S_IDLE;
            ph_q <= P_CMD;
            dec_q <= '0;
            op_q <= 8'h00;
            addr_q <= 32'h0000_0000;
            len_q <= SFC_LEN_RST;
            cfg_q <= SFC_CFG_RST;
            tx_q <= 8'h00;
            txv_q <= 1'b0;
            rej_q <= 1'b0;
            quad_q <= 1'b0;
            sh_q <= 32'h0000_0000;
            cnt_q <= 9'h000;
            div_q <= 3'h0;
            lg_q <= 2'd0;
            ld_q <= 1'b0;
            nb_q <= 4'h0;
            rx_q <= 8'h00;
            rxb_q <= 8'h00;
            push_q <= 1'b0;
            sclk_q <= 1'b0;
            cs_b_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            st_q <= st_d;
            ph_q <= ph_d;
            dec_q <= dec_d;
            op_q <= op_d;
            addr_q <= addr_d;
            len_q <= len_d;
            cfg_q <= cfg_d;
            tx_q <= tx_d;
            txv_q <= txv_d;
            rej_q <= rej_d;
            quad_q <= quad_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            div_q <= div_d;
            lg_q <= lg_d;
            ld_q <= ld_d;
            nb_q <= nb_d;
            rx_q <= rx_d;
            rxb_q <= rxb_d;
            push_q <= push_d;
            sclk_q <= sclk_d;
            cs_b_q <= cs_b_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================
    // pin drive, msb first on the lines in use
    always_comb begin
        flash_io_out = (lg_q == 2'd0) ? {3'h0, sh_q[31]} :
                       (lg_q == 2'd1) ? {2'h0, sh_q[31:30]} : sh_q[31:28];
        flash_io_oe = 4'h0;
        if (!cs_b_q && (ph_q == P_CMD || ph_q == P_ADDR || (ph_q == P_WR && !ld_q))) begin
            flash_io_oe = (lg_q == 2'd0) ? 4'h1 : (lg_q == 2'd1) ? 4'h3 : 4'hF;
        end
    end

    assign flash_cs_b = cs_b_q;
    assign flash_sclk = sclk_q;
    assign reg_rdata = rdata_q;
endmodule

`default_nettype wire

// ==== sfc_host_checker.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// port-level protocol checks
module sfc_host_checker (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // flash pins
    input wire logic flash_cs_b,
    input wire logic flash_sclk,
    input wire logic [3:0] flash_io_in,
    input wire logic [3:0] flash_io_out,
    input wire logic [3:0] flash_io_oe
);
    import sfc_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    property p_cs_gap; $rose(flash_cs_b) |-> flash_cs_b [*2]; endproperty
    a_cs_gap: assert property (p_cs_gap) else $error("deselect too short");
    property p_idle_clk; flash_cs_b && $past(flash_cs_b) |-> !flash_sclk; endproperty
    a_idle_clk: assert property (p_idle_clk) else $error("clock while idle");
    property p_idle_oe; flash_cs_b && $past(flash_cs_b) |-> flash_io_oe == 4'h0; endproperty
    a_idle_oe: assert property (p_idle_oe) else $error("drive while idle");
    property p_cs_fall; $fell(flash_cs_b) |-> !flash_sclk && flash_io_oe[0]; endproperty
    a_cs_fall: assert property (p_cs_fall) else $error("bad frame start");
    property p_half;
        $rose(flash_sclk) |-> (flash_sclk || flash_cs_b) [*4] ##1 !flash_sclk;
    endproperty
    a_half: assert property (p_half) else $error("clock high phase wrong");
    property p_hold;
        !flash_cs_b && flash_sclk && $past(flash_sclk) |-> $stable(flash_io_out & flash_io_oe);
    endproperty
    a_hold: assert property (p_hold) else $error("data moved while clock high");
    property p_start;
        reg_wr && reg_addr == SFC_REG_CTRL && reg_wdata[7:0] == SFC_OP_QUAD_IO_READ
            |-> ##[1:3] !flash_cs_b;
    endproperty
    a_start: assert property (p_start) else $error("read did not start");
    property p_rd_quiet; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("read data outside slot");
    property p_unmapped; $past(reg_rd) && $past(reg_addr) == 8'h1C |-> reg_rdata == 32'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    c_frame: cover property ($rose(flash_cs_b));
    c_data_in: cover property (!flash_cs_b && $rose(flash_sclk) && flash_io_oe == 4'h0);
    c_reg_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind sfc_host sfc_host_checker chk_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_cs_b(flash_cs_b), .flash_sclk(flash_sclk), .flash_io_in(flash_io_in),
    .flash_io_out(flash_io_out), .flash_io_oe(flash_io_oe));
`default_nettype wire

// ==== sfc_flash_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// behavioural flash device
module sfc_flash_model (
    // pins
    input wire logic cs_b,
    input wire logic sclk,
    input wire logic [3:0] io,
    output logic [3:0] io_drv,
    output logic [3:0] io_en,
    // configuration mirror
    input wire logic wide,
    input wire logic [1:0] dcfg,
    // observed state
    output logic quad = 1'b0,
    output logic [7:0] op_q = 8'h00,
    output logic [31:0] addr_q = 32'h0,
    output logic [7:0] pdat = 8'h00
);
    import sfc_pkg::*;
    logic [7:0] op = 8'h00;
    logic [31:0] ad = 32'h0;
    int cnt = 0;
    int al;
    int cc;
    int ae;
    int st;
    initial io_en = 4'h0;
    initial io_drv = 4'h0;
    always_comb begin
        cc = quad ? 2 : 8;
        if (quad || op inside {8'hEB, 8'hED, 8'h38}) al = 4;
        else if (op inside {8'hBB, 8'hBD}) al = 2;
        else al = 1;
        ae = cc + (wide ? 32 : 24) / al;
        st = ae + ((op == 8'hEB) ? 6 : int'(SFC_DUMMY_TAB[dcfg*6 +: 6]));
    end
    always @(negedge cs_b) begin
        cnt = 0;
        op = 8'h00;
        ad = 32'h0;
    end
    // samples on the rising clock edge
    always @(posedge sclk) begin
        if (cnt < cc) op = quad ? {op[3:0], io} : {op[6:0], io[0]};
        else if (cnt < ae) ad = (al == 4) ? {ad[27:0], io} :
            (al == 2) ? {ad[29:0], io[1:0]} : {ad[30:0], io[0]};
        else if (op == 8'h38 && cnt < ae + 2) pdat = {pdat[3:0], io};
        if (io_en != 4'h0 && op inside {8'hED, 8'hBD}) io_drv = ~io_drv;
        cnt = cnt + 1;
    end
    // shifts out on the falling edge, toggling pattern from the first data cycle
    always @(negedge sclk) begin
        if (!cs_b && op inside {8'hEB, 8'hED, 8'hBD, 8'h3B, 8'h6B, 8'hBB} && cnt >= st) begin
            io_drv = (io_en == 4'h0) ? 4'h5 : ~io_drv;
            io_en = 4'hF;
        end
    end
    always @(posedge cs_b) begin
        io_en = 4'h0;
        op_q = op;
        addr_q = ad;
        if (cnt == cc && op == 8'h35) quad = 1'b1;
        if (cnt == cc && op == 8'hF5) quad = 1'b0;
    end
endmodule
`default_nettype wire

// ==== sfc_host_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// self-checking bench
module sfc_host_bench;
    import sfc_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic flash_cs_b;
    logic flash_sclk;
    logic [3:0] h_out;
    logic [3:0] h_oe;
    logic [3:0] m_drv;
    logic [3:0] m_en;
    logic [3:0] io_w;
    logic wide = 1'b0;
    logic [1:0] dcfg = 2'h0;
    logic m_quad;
    logic [7:0] m_op;
    logic [7:0] m_pdat;
    logic [31:0] m_addr;
    int fail_count = 0;
    int checks_done = 0;
    int seed = 83025;
    logic [7:0] ops [6] = '{8'h3B, 8'h6B, 8'hBB, 8'hBD, 8'hED, 8'hEB};
    logic [7:0] bad [5] = '{8'h38, 8'hBD, 8'h3B, 8'h6B, 8'hBB};
    // released lines float up
    assign io_w = (m_en & m_drv) | (~m_en & h_oe & h_out) | (~m_en & ~h_oe);
    sfc_host dut_u (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flash_cs_b(flash_cs_b), .flash_sclk(flash_sclk), .flash_io_in(io_w),
        .flash_io_out(h_out), .flash_io_oe(h_oe));
    sfc_flash_model dev_u (.cs_b(flash_cs_b), .sclk(flash_sclk), .io(io_w), .io_drv(m_drv),
        .io_en(m_en), .wide(wide), .dcfg(dcfg), .quad(m_quad), .op_q(m_op), .addr_q(m_addr),
        .pdat(m_pdat));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // each toggling nibble pair packs to one fixed byte per line width
    function automatic logic [7:0] exp_byte(input logic [7:0] op);
        return (op inside {8'hBB, 8'hBD, 8'h3B}) ? 8'h66 : 8'h5A;
    endfunction
    task automatic run(input logic [7:0] op, input logic [31:0] a, input int n, input int hold,
            input int nrx, input bit ok);
        logic [31:0] s;
        logic [31:0] d;
        logic [7:0] pre;
        int got;
        pre = m_op;
        got = 0;
        wr(SFC_REG_ADDR, a);
        wr(SFC_REG_LEN, 32'(n));
        wr(SFC_REG_CTRL, {24'h0, op});
        repeat (hold) @(posedge core_clk);
        for (int k = 0; k < 2000; k++) begin
            rd(SFC_REG_STAT, s);
            if (s[4] === 1'b1) begin
                rd(SFC_REG_RXD, d);
                cmp(d, {24'h0, exp_byte(op)}, "read byte");
                got++;
            end else if (s[0] === 1'b0) begin
                break;
            end
        end
        cmp(32'(got), 32'(nrx), "byte count");
        cmp({24'h0, m_op}, {24'h0, ok ? op : pre}, "device opcode");
        if (!ok) cmp({31'h0, s[2]}, 32'h1, "refused flag");
    endtask
    initial begin
        logic [31:0] v;
        logic [31:0] a;
        int n;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(SFC_REG_CFG, v);
        cmp(v, SFC_CFG_RST, "cfg reset");
        rd(SFC_REG_LEN, v);
        cmp(v, {23'h0, SFC_LEN_RST}, "len reset");
        rd(SFC_REG_STAT, v);
        cmp(v, 32'h8, "status reset");
        rd(8'h1C, v);
        cmp(v, 32'h0, "unmapped read");
        for (int i = 0; i < 12; i++) begin
            wide <= 1'($random(seed));
            dcfg <= 2'($random(seed));
            a = $random(seed);
            n = (i == 0) ? 6 : 1 + ($random(seed) & 7);
            @(posedge core_clk);
            wr(SFC_REG_CFG, {24'h0, dcfg, 5'h00, wide});
            rd(SFC_REG_CFG, v);
            cmp(v, {24'h0, dcfg, 5'h00, wide}, "cfg readback");
            run(ops[i % 6], a, n, (i == 0) ? 600 : 0, n, 1'b1);
            cmp(m_addr, wide ? a : {8'h00, a[23:0]}, "address");
        end
        wide <= 1'b0;
        dcfg <= 2'h0;
        wr(SFC_REG_CFG, 32'h0);
        v = {24'h0, 8'($random(seed))};
        wr(SFC_REG_TXD, v);
        run(8'h38, 32'h000100, 1, 0, 0, 1'b1);
        cmp({24'h0, m_pdat}, v, "program byte");
        run(8'h35, 32'h0, 0, 0, 0, 1'b1);
        rd(SFC_REG_STAT, v);
        cmp({30'h0, v[1], m_quad}, 32'h3, "four-line mode on");
        run(8'hEB, 32'h001230, 3, 0, 3, 1'b1);
        run(8'hED, 32'h004560, 2, 0, 2, 1'b1);
        run(8'h52, 32'h018000, 0, 0, 0, 1'b1);
        cmp(m_addr, 32'h018000, "erase address");
        for (int i = 0; i < 5; i++) run(bad[i], 32'h0, 1, 0, 0, 1'b0);
        run(8'hF5, 32'h0, 0, 0, 0, 1'b1);
        rd(SFC_REG_STAT, v);
        cmp({30'h0, v[1], m_quad}, 32'h0, "four-line mode off");
        run(8'h6B, 32'h000040, 2, 0, 2, 1'b1);
        stop_test();
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        fail_count++;
        stop_test();
    end
endmodule
`default_nettype wire
